// ===== verilog/dto_defines.svh
// constants of the dedicated channel timing offset block
`ifndef DTO_DEFINES_SVH
`define DTO_DEFINES_SVH

// register indices on the plain register port
`define DTO_REG_CTRL      4'h0
`define DTO_REG_SFN_REF   4'h1
`define DTO_REG_SFN_CELL  4'h2
`define DTO_REG_CFN       4'h3
`define DTO_REG_SUBST     4'h4
`define DTO_REG_DOFF_FDD  4'h5
`define DTO_REG_DOFF_TDD  4'h6
`define DTO_REG_FRAME_OFF 4'h7
`define DTO_REG_CHIP_OFF  4'h8
`define DTO_REG_OFF       4'h9
`define DTO_REG_TIMING    4'ha
`define DTO_REG_STATUS    4'hb

// control register field positions
`define DTO_CTRL_CASE_LSB 0
`define DTO_CTRL_CASE_MSB 2
`define DTO_CTRL_IS_REF   3
`define DTO_CTRL_MEAS     4
`define DTO_CTRL_TDD      5
`define DTO_CTRL_FIRST    6

// status register field positions
`define DTO_STAT_CHIP_ERR 0
`define DTO_STAT_DOFF_ERR 1

// timing figures in chips and codes
`define DTO_CHIPS_PER_FRAME 24'h009600
`define DTO_CHIP_MAX        16'h95ff
`define DTO_DOFF_FDD_MAX    10'h257
`define DTO_DOFF_FDD_SHIFT  9
`define DTO_FDD_FRAMES_MAX  7
`define DTO_BOUND_MASK      24'hffff00
`define DTO_BOUND_STEP      24'h000100
`define DTO_HALF_BOUND      8'h80
`define DTO_ZERO_LOW        8'h00

`endif

// ===== verilog/dto_pkg.sv
// types of the dedicated channel timing offset block
package dto_pkg;

  typedef enum logic [2:0] {
    DTO_CASE_NONE        = 3'b000,
    DTO_CASE_SINGLE      = 3'b001,
    DTO_CASE_MULTI       = 3'b010,
    DTO_CASE_DCH_ADD     = 3'b011,
    DTO_CASE_IRAT_SINGLE = 3'b100,
    DTO_CASE_IRAT_MULTI  = 3'b101
  } dto_case_t;

  typedef struct packed {
    dto_case_t   off_case;
    logic        cell_is_ref;
    logic        measurable;
    logic        tdd;
    logic        first_link;
    logic [7:0]  sfn_ref;
    logic [7:0]  sfn_cell;
    logic [7:0]  cfn;
    logic [7:0]  off_subst;
    logic [9:0]  doff_fdd;
    logic [2:0]  doff_tdd;
    logic [7:0]  frame_off;
    logic [15:0] chip_off;
    logic        err_chip;
    logic        err_doff;
  } dto_cfg_t;

  typedef struct packed {
    logic [7:0]  off_report;
    logic [23:0] dl_offset;
    logic [31:0] rdata;
  } dto_out_t;

endpackage

// ===== verilog/dto_core.sv
// offset report and downlink timing offset computation with register port
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`include "dto_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// - common to dedicated, several links: offset zero for the uplink message cell.
// - other cells in that case report own frame number minus first cell's.
// - adding a link or moving cell: connection frame minus target frame number.
// - if that difference is unmeasurable, the substitute value is reported.
// - single link from another network behaves as single link case, zero.
// - several links from elsewhere: zero for chosen reference, others relative to it.
// - default offset for FDD uses 512-chip steps, codes 0 to 599.
// - default offset for TDD is 0 to 7 frames, sets frame offset.
// - chip offset has one-chip steps, range 0 to 38399.
// - the FDD default offset gives frame and chip offset at first setup.
// - frame offset times 38400 plus chip offset rounded to 256 chips.
// - remainder 1 to 127 rounds down to the lower 256-chip boundary.
// - remainder 128 to 255 rounds up to the next boundary.
// - remainder zero leaves the combined value unchanged.
// - downlink timing output is the rounded combined offset.
// - frame numbers and offsets are eight bits, arithmetic wraps modulo 256.
module dto_core #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  output logic      [7:0]        off_report,
  output logic      [23:0]       dl_offset
);

  // ==========================================================
  // state
  dto_pkg::dto_cfg_t cfg;
  dto_pkg::dto_cfg_t next_cfg;
  dto_pkg::dto_out_t outs;
  dto_pkg::dto_out_t next_outs;

  logic [7:0]  eff_frame;
  logic [15:0] eff_chip;
  logic [23:0] sum;
  logic [23:0] rounded;
  logic [7:0]  off_calc;
  logic [18:0] fdd_chips;
  logic [18:0] fdd_rem;
  logic [3:0]  a;

  assign a = ADDR_W'(addr) > ADDR_W'(4'hf) ? 4'hf : addr[3:0];

  // ==========================================================
  // register writes
  always_comb begin
    next_cfg = cfg;
    if (wr) begin
      if (a == `DTO_REG_CTRL) begin
        next_cfg.off_case    = dto_pkg::dto_case_t'(
                                 wdata[`DTO_CTRL_CASE_MSB:`DTO_CTRL_CASE_LSB]);
        next_cfg.cell_is_ref = wdata[`DTO_CTRL_IS_REF];
        next_cfg.measurable  = wdata[`DTO_CTRL_MEAS];
        next_cfg.tdd         = wdata[`DTO_CTRL_TDD];
        next_cfg.first_link  = wdata[`DTO_CTRL_FIRST];
      end else if (a == `DTO_REG_SFN_REF) begin
        next_cfg.sfn_ref = wdata[7:0];
      end else if (a == `DTO_REG_SFN_CELL) begin
        next_cfg.sfn_cell = wdata[7:0];
      end else if (a == `DTO_REG_CFN) begin
        next_cfg.cfn = wdata[7:0];
      end else if (a == `DTO_REG_SUBST) begin
        next_cfg.off_subst = wdata[7:0];
      end else if (a == `DTO_REG_DOFF_FDD) begin
        if (wdata[31:10] == 22'h0 && wdata[9:0] <= `DTO_DOFF_FDD_MAX) begin
          next_cfg.doff_fdd = wdata[9:0];
        end else begin
          next_cfg.err_doff = 1'b1;
        end
      end else if (a == `DTO_REG_DOFF_TDD) begin
        next_cfg.doff_tdd = wdata[2:0];
      end else if (a == `DTO_REG_FRAME_OFF) begin
        next_cfg.frame_off = wdata[7:0];
      end else if (a == `DTO_REG_CHIP_OFF) begin
        if (wdata[31:16] == 16'h0000 && wdata[15:0] <= `DTO_CHIP_MAX) begin
          next_cfg.chip_off = wdata[15:0];
        end else begin
          next_cfg.err_chip = 1'b1;
        end
      end else if (a == `DTO_REG_STATUS) begin
        // write one to clear; a refused write cannot share the cycle
        if (wdata[`DTO_STAT_CHIP_ERR]) begin
          next_cfg.err_chip = 1'b0;
        end
        if (wdata[`DTO_STAT_DOFF_ERR]) begin
          next_cfg.err_doff = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '0;
    end else if (ce) begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // offset split and rounding
  always_comb begin
    // default code times 512 in chips
    fdd_chips = {cfg.doff_fdd, 9'h000};
    fdd_rem   = fdd_chips;
    eff_frame = cfg.frame_off;
    eff_chip  = cfg.chip_off;
    if (cfg.first_link && !cfg.tdd) begin
      // frame and chip offset from the default code
      eff_frame = 8'h00;
      for (int i = 0; i < `DTO_FDD_FRAMES_MAX; i++) begin
        if (fdd_rem >= 19'(`DTO_CHIPS_PER_FRAME)) begin
          fdd_rem   = fdd_rem - 19'(`DTO_CHIPS_PER_FRAME);
          eff_frame = eff_frame + 8'h01;
        end
      end
      eff_chip = fdd_rem[15:0];
    end else if (cfg.first_link && cfg.tdd) begin
      // frame offset from the default frame code
      eff_frame = {5'h00, cfg.doff_tdd};
      eff_chip  = 16'h0000;
    end
    // frame offset times frame length plus chip offset
    sum = {16'h0000, eff_frame} * `DTO_CHIPS_PER_FRAME + {8'h00, eff_chip};
    if (sum[7:0] == `DTO_ZERO_LOW) begin
      rounded = sum;
    end else if (sum[7:0] < `DTO_HALF_BOUND) begin
      rounded = sum & `DTO_BOUND_MASK;
    end else begin
      rounded = (sum & `DTO_BOUND_MASK) + `DTO_BOUND_STEP;
    end
  end

  // ==========================================================
  // reported frame offset
  always_comb begin
    off_calc = 8'h00;
    case (cfg.off_case)
      // cell of the uplink message reports zero
      // other cells relative to the first cell
      // same relation to the selected reference cell
      dto_pkg::DTO_CASE_MULTI, dto_pkg::DTO_CASE_IRAT_MULTI: begin
        off_calc = cfg.cell_is_ref ? 8'h00 : cfg.sfn_cell - cfg.sfn_ref;
      end
      dto_pkg::DTO_CASE_DCH_ADD: begin
        off_calc = cfg.measurable ? cfg.cfn - cfg.sfn_cell : cfg.off_subst;
      end
      default: begin
        off_calc = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // outputs and read data
  always_comb begin
    next_outs = outs;
    next_outs.off_report = off_calc;
    // timing output follows the rounded value
    next_outs.dl_offset = rounded;
    next_outs.rdata = 32'h00000000;
    if (rd) begin
      if (a == `DTO_REG_CTRL) begin
        next_outs.rdata = {25'h0, cfg.first_link, cfg.tdd, cfg.measurable,
                           cfg.cell_is_ref, cfg.off_case};
      end else if (a == `DTO_REG_SFN_REF) begin
        next_outs.rdata = {24'h000000, cfg.sfn_ref};
      end else if (a == `DTO_REG_SFN_CELL) begin
        next_outs.rdata = {24'h000000, cfg.sfn_cell};
      end else if (a == `DTO_REG_CFN) begin
        next_outs.rdata = {24'h000000, cfg.cfn};
      end else if (a == `DTO_REG_SUBST) begin
        next_outs.rdata = {24'h000000, cfg.off_subst};
      end else if (a == `DTO_REG_DOFF_FDD) begin
        next_outs.rdata = {22'h0, cfg.doff_fdd};
      end else if (a == `DTO_REG_DOFF_TDD) begin
        next_outs.rdata = {29'h0, cfg.doff_tdd};
      end else if (a == `DTO_REG_FRAME_OFF) begin
        next_outs.rdata = {24'h000000, cfg.frame_off};
      end else if (a == `DTO_REG_CHIP_OFF) begin
        next_outs.rdata = {16'h0000, cfg.chip_off};
      end else if (a == `DTO_REG_OFF) begin
        next_outs.rdata = {24'h000000, outs.off_report};
      end else if (a == `DTO_REG_TIMING) begin
        next_outs.rdata = {8'h00, outs.dl_offset};
      end else if (a == `DTO_REG_STATUS) begin
        next_outs.rdata = {30'h0, cfg.err_doff, cfg.err_chip};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      outs <= '0;
    end else if (ce) begin
      outs <= next_outs;
    end
  end

  assign rdata      = outs.rdata;
  assign off_report = outs.off_report;
  assign dl_offset  = outs.dl_offset;

  // ==========================================================
  // checks
  round_down_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && sum[7:0] != 8'h00 && sum[7:0] < 8'h80
    |=> dl_offset == {$past(sum[23:8]), 8'h00})
    else $error("combined offset not rounded down");

  round_up_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && sum[7:0] >= 8'h80 |=> dl_offset == {$past(sum[23:8]) + 16'h0001, 8'h00})
    else $error("combined offset not rounded up");

  round_exact_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && sum[7:0] == 8'h00 |=> dl_offset == $past(sum))
    else $error("boundary value changed");

  combined_sum_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && !cfg.first_link
    |=> dl_offset[23:8] == 16'((($past(cfg.frame_off) * 24'd38400)
                               + $past(cfg.chip_off) + 24'd128) >> 8))
    else $error("combined offset wrong");

  fdd_default_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    cfg.first_link && !cfg.tdd
    |-> eff_chip < 16'd38400 && sum == {5'h00, cfg.doff_fdd, 9'h000})
    else $error("default offset split wrong");

  tdd_default_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && cfg.first_link && cfg.tdd
    |=> dl_offset == 24'(($past(cfg.doff_tdd)) * 24'd38400))
    else $error("tdd default frame offset wrong");

  off_single_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && (cfg.off_case == dto_pkg::DTO_CASE_SINGLE ||
           cfg.off_case == dto_pkg::DTO_CASE_IRAT_SINGLE) |=> off_report == 8'h00)
    else $error("single link offset not zero");

  off_multi_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && cfg.off_case == dto_pkg::DTO_CASE_MULTI && !cfg.cell_is_ref
    |=> off_report == 8'($past(cfg.sfn_cell) - $past(cfg.sfn_ref)))
    else $error("multi link offset wrong");

  off_add_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && cfg.off_case == dto_pkg::DTO_CASE_DCH_ADD && cfg.measurable
    |=> off_report == 8'($past(cfg.cfn) - $past(cfg.sfn_cell)))
    else $error("added link offset wrong");

  off_subst_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && cfg.off_case == dto_pkg::DTO_CASE_DCH_ADD && !cfg.measurable
    |=> off_report == $past(cfg.off_subst))
    else $error("substitute not reported");

  chip_range_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && wr && a == `DTO_REG_CHIP_OFF && wdata > 32'd38399
    |=> $stable(cfg.chip_off) && cfg.err_chip)
    else $error("out of range chip offset taken");

  doff_range_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && wr && a == `DTO_REG_DOFF_FDD && wdata > 32'd599
    |=> $stable(cfg.doff_fdd) && cfg.err_doff)
    else $error("out of range default code taken");

endmodule

`default_nettype wire

// ===== test/dto_host_model.sv
// controller side model driving the offset block register port
`timescale 1ns/1ps
`default_nettype none

module dto_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  output var  logic [3:0]  addr,
  output var  logic [31:0] wdata,
  output var  logic        wr,
  output var  logic        rd
);
  // idle levels, driven from the caller's process so each line has one driver
  task automatic idle();
    addr <= 4'h0;
    wdata <= 32'h0;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // released lines show the inverse so stale values never look valid
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    q = rdata;
  endtask

  task automatic send_link(input logic [9:0] code, input logic [7:0] fo, input logic [15:0] co);
    wr_reg(4'h5, 32'(code));
    wr_reg(4'h7, 32'(fo));
    wr_reg(4'h8, 32'(co));
  endtask
endmodule

`default_nettype wire

// ===== test/dto_core_tb_top.sv
// self-checking bench of the offset block
`timescale 1ns/1ps
`default_nettype none

module dto_core_tb_top;
  logic        clk;
  logic        arst_n;
  logic        ce;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr;
  logic        rd;
  logic [7:0]  off_report;
  logic [23:0] dl_offset;
  logic [31:0] q;
  logic [7:0]  e_off;
  logic [23:0] e_dl;
  int          n_errors;
  int          cmp_count;
  logic [15:0] cor [6] = '{16'h0000, 16'h0001, 16'h007f, 16'h0080, 16'h00ff, 16'h95ff};

  dto_core uut (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
                .rd(rd), .rdata(rdata), .off_report(off_report), .dl_offset(dl_offset));
  dto_host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] exp_off(logic [6:0] c, logic [7:0] r, s, f, u);
    case (c[2:0])
      3'h2, 3'h5: return c[3] ? 8'h00 : s - r;
      3'h3: return c[4] ? f - s : u;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [23:0] exp_dl(logic [6:0] c, logic [9:0] code, logic [2:0] td,
                                         logic [7:0] fo, logic [15:0] co);
    logic [23:0] sum;
    if (c[6] && !c[5]) sum = 24'(code) << 9;
    else if (c[6]) sum = 24'(td) * 24'h009600;
    else sum = 24'(fo) * 24'h009600 + 24'(co);
    if (sum[7:0] == 8'h00) return sum;
    if (sum[7:0] < 8'h80) return {sum[23:8], 8'h00};
    return {sum[23:8], 8'h00} + 24'h000100;
  endfunction

  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_port();
    cmp_count += 2;
    if (off_report !== e_off) begin
      n_errors++;
      $display("Error %0t: off_report %h expected %h", $time, off_report, e_off);
    end
    if (dl_offset !== e_dl) begin
      n_errors++;
      $display("Error %0t: dl_offset %h expected %h", $time, dl_offset, e_dl);
    end
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    host.rd_reg(a, q);
    cmp_count++;
    if (q !== e) begin
      n_errors++;
      $display("Error %0t: read %h gave %h expected %h", $time, a, q, e);
    end
  endtask

  task automatic run(input logic [6:0] c, input logic [7:0] r, s, f, u, input logic [9:0] code,
                     input logic [2:0] td, input logic [7:0] fo, input logic [15:0] co);
    host.wr_reg(4'h1, 32'(r));
    host.wr_reg(4'h2, 32'(s));
    host.wr_reg(4'h3, 32'(f));
    host.wr_reg(4'h4, 32'(u));
    host.wr_reg(4'h6, 32'(td));
    host.send_link(code, fo, co);
    host.wr_reg(4'h0, 32'(c));
    e_off = exp_off(c, r, s, f, u);
    e_dl = exp_dl(c, code, td, fo, co);
    repeat (2) @(posedge clk);
    #1;
    chk_port();
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    host.idle();
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    void'($urandom(18254));
    foreach (cor[i]) run(7'h00, 8'h0, 8'h0, 8'h0, 8'h0, 10'h0, 3'h0, 8'hff, cor[i]);
    run(7'h40, 8'h0, 8'h0, 8'h0, 8'h0, 10'h257, 3'h0, 8'h0, 16'h0);
    run(7'h60, 8'h0, 8'h0, 8'h0, 8'h0, 10'h0, 3'h7, 8'h0, 16'h0);
    run(7'h0b, 8'hf0, 8'h10, 8'h05, 8'h3c, 10'h0, 3'h0, 8'h0, 16'h0);
    for (int i = 0; i < 200; i++) begin
      run(7'($urandom_range(0, 127)), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
          10'($urandom_range(0, 599)), 3'($urandom), 8'($urandom),
          16'($urandom_range(0, 38399)));
    end
    // writes while the clock enable is low must leave everything frozen
    @(posedge clk);
    ce <= 1'b0;
    host.wr_reg(4'h4, 32'(~e_off));
    host.wr_reg(4'h0, 32'h00000003);
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    #1;
    chk_port();
    // out of range writes must be ignored and flagged
    host.wr_reg(4'h8, 32'h00009600);
    host.wr_reg(4'h5, 32'h00000258);
    repeat (2) @(posedge clk);
    #1;
    chk_port();
    chk_rd(4'hb, 32'h00000003);
    host.wr_reg(4'hb, 32'h00000003);
    chk_rd(4'hb, 32'h00000000);
    chk_rd(4'hc, 32'h00000000);
    chk_rd(4'h9, 32'(e_off));
    chk_rd(4'ha, 32'(e_dl));
    tally_and_finish();
  end
endmodule

`default_nettype wire
